// [lpgd_core.sv]
// led pwm gradation driver: serial register port, pwm, gradation, protection
//
// Contract
// - each channel has an 8-bit pwm repeating at 31.25 kHz from the oscillator
// - individual duty spans off to fully on over 256 codes
// - group pwm dims at 122 Hz or blinks from 15 Hz to one per 16.8 s
// - group duty reaches at most 99.6 percent, never constant on
// - channel mode is off, on, individual pwm, or individual and group pwm
// - each channel holds an 8-bit current code independent of duty
// - six gradation groups each with ramp, step, hold and final current settings
// - a group runs the pattern once or repeats it continuously
// - each channel picks normal or gradation mode and follows its group
// - ramp up, down or both may be enabled, with programmable increment
// - 6-bit step time covers 0.5 ms to 512 ms
// - hold on after ramp up, hold off after ramp down, 0 s to 6 s
// - gradation current follows a linear or exponential curve
// - programmable turn-on delay staggers the channel outputs
// - output enable high turns every channel off
// - serial data out is low while chip select is high
// - open, short and overtemperature are caught in readable error flags
// - thermal shutdown disables the channel outputs
// - all pwm and gradation timing comes from the 8 MHz oscillator
// - reset at power-on or reset pin low, outputs do not glitch
// - after reset group brightness is maximum, channel brightness off
// - each access is 16 bits per device, msb first, after chip select falls
// - word is 7 address bits, read/write bit, then 8 data bits
`timescale 1ns/1ps
module lpgd_core
  import lpgd_pkg::*;
#(
  parameter int P_OSC_DIV = OSC_DIV,
  parameter int P_HALF_MS_OSC = HALF_MS_OSC,
  parameter int P_DLY = 1
) (
  input wire logic i_core_clk, // core clock, 200 MHz
  input wire logic i_sys_rst, // power-on reset, high
  input wire logic i_ce, // clock enable, freezes all state when low
  input wire logic i_reset_n, // reset pin, low active
  input wire logic i_oe_n, // output enable pin, low active
  input wire logic i_cs_n, // chip select pin, low active
  input wire logic i_sclk, // serial clock pin
  input wire logic i_sdi, // serial data in pin
  input wire logic i_tsd, // thermal shutdown indication
  input wire logic [NCH-1:0] i_open_det, // per channel open-load detect
  input wire logic [NCH-1:0] i_short_det, // per channel short detect
  output logic o_sdo, // serial data out
  output logic [NCH-1:0] o_channel_sink_out, // sink enables
  output logic [NCH-1:0][7:0] o_current_code // per channel current dac code
);

  lpgd_pin_s pin_m, pin_s, pin_d;
  logic [NCH-1:0] open_m, open_s, short_m, short_s;
  logic rst;
  logic [7:0] regs [NREG];
  logic [$clog2(OSC_DIV+1)+4:0] odiv;
  logic osc_tick;
  logic [7:0] pcnt;
  logic pwm_wrap;
  logic [10:0] bdiv;
  logic [7:0] gcnt;
  logic gtick;
  logic grp_on;
  logic [31:0] hcnt;
  logic ms_tick;
  logic [WORD_BITS-1:0] sreg;
  logic [4:0] nbits;
  logic sclk_rise, cs_rise, commit, wr;
  logic [NCH-1:0] eopen, eshort;
  logic eovt, clr_err;
  logic [NGRP-1:0] grad_done;
  logic [NGRP-1:0][7:0] glevel;

  // register read view; error flags and overtemp come from live sticky bits
  function automatic logic [7:0] rd(input logic [6:0] a);
    logic [7:0] v;
    int k;
    v = 8'h00;
    k = 0;
    if (a >= A_EFLAG0 && a <= A_EFLAG5) begin
      k = 4 * int'(a - A_EFLAG0);
      for (int j = 0; j < 4; j++) begin
        v[2*j+:2] = {eopen[k+j], eshort[k+j]};
      end
    end else if (a == A_MODE2) begin
      v = regs[A_MODE2];
      v[M2_OVT] = eovt;
      v[M2_CLRERR] = 1'b0;
    end else if (int'(a) < NREG) begin
      v = regs[a];
    end
    return v;
  endfunction

  // reset value of each register
  function automatic logic [7:0] rst_val(input int a);
    logic [7:0] v;
    v = 8'h00;
    if (a == int'(A_MODE2)) v = 8'h01;
    if (a >= int'(A_LEDOUT0) && a < int'(A_GRPPWM)) v = 8'haa;
    if (a == int'(A_GRPPWM)) v = 8'hff;
    // two channels per select register, so the group number steps every second address
    if (a >= int'(A_GSEL0) + 2 && a < int'(A_GSEL0) + NCH / 2) v = 8'((a - int'(A_GSEL0)) / 2 * 8'h11);
    return v;
  endfunction

  // hold time code to half-ms steps
  function automatic logic [13:0] hold_len(input logic [2:0] c);
    return 14'(HOLD_MS[c] * 1000 / STEP_BASE_US);
  endfunction

  // pin synchronisers; second stage feeds logic, third stage only for edges
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pin_m <= '{rst_n: 1'b1, oe_n: 1'b1, cs_n: 1'b1, default: 1'b0};
      pin_s <= '{rst_n: 1'b1, oe_n: 1'b1, cs_n: 1'b1, default: 1'b0};
      pin_d <= '{rst_n: 1'b1, oe_n: 1'b1, cs_n: 1'b1, default: 1'b0};
      open_m <= '0;
      open_s <= '0;
      short_m <= '0;
      short_s <= '0;
    end else if (i_ce) begin
      pin_m <= '{i_reset_n, i_oe_n, i_cs_n, i_sclk, i_sdi, i_tsd};
      pin_s <= pin_m;
      pin_d <= pin_s;
      open_m <= i_open_det;
      open_s <= open_m;
      short_m <= i_short_det;
      short_s <= short_m;
    end
  end

  assign rst = i_sys_rst | ~pin_s.rst_n;

  // 8 MHz timebase; every pwm and gradation timer hangs off this tick
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      odiv <= '0;
    end else if (i_ce) begin
      odiv <= osc_tick ? '0 : odiv + 1'b1;
    end
  end
  assign osc_tick = (int'(odiv) == P_OSC_DIV - 1);

  // individual pwm counter, 256 oscillator ticks per period
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      pcnt <= '0;
    end else if (i_ce && osc_tick) begin
      pcnt <= pcnt + 8'h01;
    end
  end
  assign pwm_wrap = osc_tick && pcnt == PWM_FULL;

  // group pwm: one step per pwm period when dimming, slower when blinking
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      bdiv <= '0;
      gcnt <= '0;
    end else if (i_ce && pwm_wrap) begin
      bdiv <= gtick ? '0 : bdiv + 11'h001;
      if (gtick) gcnt <= gcnt + 8'h01;
    end
  end
  assign gtick = !regs[A_MODE2][M2_BLINK] ||
    bdiv == 11'((int'(regs[A_GRPFREQ]) + 1) * BLINK_PRESCALE - 1);
  // strict compare keeps code ff one step short of always on
  assign grp_on = gcnt < regs[A_GRPPWM];

  // half-ms gradation tick
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      hcnt <= '0;
    end else if (i_ce && osc_tick) begin
      hcnt <= ms_tick ? '0 : hcnt + 32'd1;
    end
  end
  assign ms_tick = osc_tick && int'(hcnt) == P_HALF_MS_OSC - 1;

  // serial port edges from synchronised pins
  assign sclk_rise = pin_s.sclk && !pin_d.sclk && !pin_s.cs_n;
  assign cs_rise = pin_s.cs_n && !pin_d.cs_n;
  assign commit = cs_rise && nbits[4];
  assign wr = commit && !sreg[8];

  // shift register doubles as the 16-bit chain delay
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      sreg <= '0;
      nbits <= '0;
    end else if (i_ce) begin
      if (sclk_rise) begin
        sreg <= {sreg[WORD_BITS-2:0], pin_s.sdi};
        if (!nbits[4]) nbits <= nbits + 5'h01;
      end else if (cs_rise) begin
        nbits <= '0;
        if (commit && sreg[8]) sreg[7:0] <= rd(sreg[15:9]);
      end
    end
  end

  // serial output, held low outside a frame
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      o_sdo <= 1'b0;
    end else if (i_ce) begin
      o_sdo <= pin_s.cs_n ? 1'b0 : sreg[WORD_BITS-1];
    end
  end

  // register file; software set of a start bit wins over hardware clear
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) regs[i] <= rst_val(i);
    end else if (i_ce) begin
      for (int g = 0; g < NGRP; g++) begin
        if (grad_done[g]) regs[A_GSTART][g] <= 1'b0;
      end
      if (wr && int'(sreg[15:9]) < NREG && !(sreg[15:9] >= A_EFLAG0 && sreg[15:9] <= A_EFLAG5)) begin
        regs[sreg[15:9]] <= sreg[7:0];
      end
    end
  end
  assign clr_err = wr && sreg[15:9] == A_MODE2 && sreg[M2_CLRERR];

  // sticky error flags; a new event beats a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      eopen <= '0;
      eshort <= '0;
      eovt <= 1'b0;
    end else if (i_ce) begin
      eopen <= (clr_err ? '0 : eopen) | open_s;
      eshort <= (clr_err ? '0 : eshort) | short_s;
      eovt <= (clr_err ? 1'b0 : eovt) | pin_s.tsd;
    end
  end

  // gradation engines, one per group
  for (genvar g = 0; g < NGRP; g++) begin : g_grad
    lpgd_gstate_e st;
    logic [7:0] lvl, ramp, stp, hold, igrp;
    logic [13:0] tcnt;
    logic [10:0] step_len;
    logic step_due, run, cont;
    assign ramp = regs[A_GRP0 + 7'(4 * g)];
    assign stp = regs[A_GRP0 + 7'(4 * g + 1)];
    assign hold = regs[A_GRP0 + 7'(4 * g + 2)];
    assign igrp = regs[A_GRP0 + 7'(4 * g + 3)];
    assign run = regs[A_GSTART][g];
    assign cont = regs[A_GCONT][g];
    assign step_len = stp[ST_LONG] ? 11'((int'(stp[5:0]) + 1) * ST_LONG_UNITS)
      : 11'(int'(stp[5:0]) + 1);
    assign step_due = ms_tick && tcnt >= 14'(step_len - 11'h001);

    always_ff @(posedge i_core_clk) begin
      if (rst) begin
        st <= G_IDLE;
        lvl <= '0;
        tcnt <= '0;
        grad_done[g] <= 1'b0;
      end else if (i_ce) begin
        grad_done[g] <= 1'b0;
        if (ms_tick) tcnt <= tcnt + 14'h0001;
        unique case (st)
          G_IDLE: begin
            tcnt <= '0;
            // start bit is still set the cycle after a single shot ends; do not rerun then
            if (run && !grad_done[g]) begin
              st <= ramp[RR_UP] ? G_UP : G_HON;
              lvl <= ramp[RR_UP] ? 8'h00 : igrp;
            end
          end
          G_UP: begin
            if (step_due) begin
              tcnt <= '0;
              if (9'(lvl) + 9'(ramp[5:0]) >= 9'(igrp)) begin
                lvl <= igrp;
                st <= G_HON;
              end else begin
                lvl <= lvl + 8'(ramp[5:0]);
              end
            end
          end
          G_HON: begin
            if (!hold[HC_ON] || tcnt >= hold_len(hold[5:3])) begin
              tcnt <= '0;
              st <= ramp[RR_DN] ? G_DOWN : G_HOFF;
              if (!ramp[RR_DN]) lvl <= '0;
            end
          end
          G_DOWN: begin
            if (step_due) begin
              tcnt <= '0;
              if (lvl <= 8'(ramp[5:0])) begin
                lvl <= '0;
                st <= G_HOFF;
              end else begin
                lvl <= lvl - 8'(ramp[5:0]);
              end
            end
          end
          G_HOFF: begin
            if (!hold[HC_OFF] || tcnt >= hold_len(hold[2:0])) begin
              tcnt <= '0;
              if (cont && run) begin
                st <= ramp[RR_UP] ? G_UP : G_HON;
                lvl <= ramp[RR_UP] ? 8'h00 : igrp;
              end else begin
                st <= G_IDLE;
                grad_done[g] <= 1'b1;
              end
            end
          end
        endcase
        if (!run && st != G_IDLE) st <= G_IDLE;
      end
    end

    // exponential curve approximated by squaring the linear level
    assign glevel[g] = regs[A_MODE1][M1_EXP]
      ? 8'((16'(lvl) * 16'(lvl) + 16'h00ff) >> 8) : lvl;

    hon_level_a: assert property (@(posedge i_core_clk) disable iff (rst)
      st == G_UP && i_ce |=> st inside {G_UP, G_HON, G_IDLE} && lvl <= igrp)
      else $error("ramp level passed final current");
  end

  // channel outputs
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    lpgd_ledmode_e mode;
    logic [7:0] duty, phase, gsel;
    logic ind_on, on;
    assign mode = lpgd_ledmode_e'(regs[A_LEDOUT0 + 7'(c / 4)][2*(c%4)+:2]);
    assign duty = regs[A_PWM0 + 7'(c)];
    assign gsel = {4'h0, regs[A_GSEL0 + 7'(c / 2)][4*(c%2)+:4]};
    // staggered edges spread the inrush over the period
    assign phase = pcnt - (regs[A_MODE1][M1_DLY] ? 8'(c * P_DLY) : 8'h00);
    assign ind_on = duty == PWM_FULL || phase < duty;
    always_comb begin
      unique case (mode)
        LM_OFF: on = 1'b0;
        LM_ON: on = 1'b1;
        LM_IND: on = ind_on;
        LM_GRP: on = ind_on && grp_on;
      endcase
    end

    always_ff @(posedge i_core_clk) begin
      if (rst) begin
        o_channel_sink_out[c] <= 1'b0;
        o_current_code[c] <= '0;
      end else if (i_ce) begin
        o_channel_sink_out[c] <= on && !pin_s.oe_n && !pin_s.tsd;
        if (regs[A_GMODE0 + 7'(c / 8)][c%8]) begin
          o_current_code[c] <= gsel < 8'(NGRP) ? glevel[gsel[2:0]] : 8'h00;
        end else begin
          o_current_code[c] <= regs[A_IREF0 + 7'(c)];
        end
      end
    end
  end

  // checks
  logic [15:0] wrap_gap;
  logic wrap_seen;
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      wrap_gap <= '0;
      wrap_seen <= 1'b0;
    end else if (i_ce) begin
      wrap_gap <= pwm_wrap ? '0 : wrap_gap + 16'h0001;
      if (pwm_wrap) wrap_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (rst);

  sequence s_commit_grppwm;
    wr && sreg[15:9] == A_GRPPWM && i_ce;
  endsequence

  sdo_idle_low_a: assert property (pin_s.cs_n && i_ce |=> !o_sdo)
    else $error("serial out not low outside frame");
  oe_blank_a: assert property (pin_s.oe_n && i_ce |=> o_channel_sink_out == '0)
    else $error("output active while disabled");
  tsd_blank_a: assert property (pin_s.tsd && i_ce |=> o_channel_sink_out == '0)
    else $error("output active in thermal shutdown");
  reset_dflt_a: assert property ($past(rst) |-> regs[A_GRPPWM] == 8'hff && regs[A_PWM0] == 8'h00)
    else $error("wrong brightness after reset");
  pwm_period_a: assert property (pwm_wrap && wrap_seen && i_ce |->
    wrap_gap == 16'(PWM_OSC * P_OSC_DIV - 1)) else $error("pwm period wrong");
  grp_not_full_a: assert property (gcnt == PWM_FULL |-> !grp_on)
    else $error("group pwm stuck on");
  reg_write_a: assert property (s_commit_grppwm |=> regs[A_GRPPWM] == $past(sreg[7:0]))
    else $error("write not committed");
  err_sticky_a: assert property (short_s[0] && i_ce |=> eshort[0] ##1 (eshort[0] || $past(clr_err)))
    else $error("short flag not held");
  chain_delay_a: assert property (sclk_rise && i_ce ##1 (!sclk_rise && !cs_rise) [*2]
    |-> sreg[0] == $past(pin_s.sdi, 2)) else $error("chain bit lost");
  grp_dim_step_a: assert property (!regs[A_MODE2][M2_BLINK] && pwm_wrap && i_ce |=>
    gcnt == $past(gcnt) + 8'h01) else $error("group dim step missed");

endmodule // lpgd_core

// [lpgd_pkg.sv]
// shared constants and types for the led pwm gradation driver
package lpgd_pkg;
  localparam int CORE_HZ = 200_000_000;
  localparam int OSC_HZ = 8_000_000;
  localparam int OSC_DIV = CORE_HZ / OSC_HZ;
  localparam int PWM_HZ = 31_250;
  localparam int PWM_OSC = OSC_HZ / PWM_HZ;
  localparam int STEP_BASE_US = 500;
  localparam int HALF_MS_OSC = OSC_HZ / 1_000_000 * STEP_BASE_US;
  localparam int BLINK_PRESCALE = 8;
  localparam int NCH = 24;
  localparam int NGRP = 6;
  localparam int WORD_BITS = 16;
  localparam int NREG = 8'h6a;
  // register addresses
  localparam logic [6:0] A_MODE1 = 7'h00;
  localparam logic [6:0] A_MODE2 = 7'h01;
  localparam logic [6:0] A_EFLAG0 = 7'h02;
  localparam logic [6:0] A_EFLAG5 = 7'h07;
  localparam logic [6:0] A_LEDOUT0 = 7'h08;
  localparam logic [6:0] A_GRPPWM = 7'h0e;
  localparam logic [6:0] A_GRPFREQ = 7'h0f;
  localparam logic [6:0] A_PWM0 = 7'h10;
  localparam logic [6:0] A_IREF0 = 7'h28;
  localparam logic [6:0] A_GRP0 = 7'h40;
  localparam logic [6:0] A_GMODE0 = 7'h58;
  localparam logic [6:0] A_GSEL0 = 7'h5b;
  localparam logic [6:0] A_GSTART = 7'h68;
  localparam logic [6:0] A_GCONT = 7'h69;
  // field positions
  localparam int M1_EXP = 0;
  localparam int M1_DLY = 1;
  localparam int M2_CLRERR = 4;
  localparam int M2_BLINK = 5;
  localparam int M2_OVT = 7;
  localparam int RR_UP = 7;
  localparam int RR_DN = 6;
  localparam int ST_LONG = 6;
  localparam int HC_ON = 7;
  localparam int HC_OFF = 6;
  localparam int ST_LONG_UNITS = 16;
  localparam logic [7:0] PWM_FULL = 8'hff;
  // hold times in ms, scaled to half-ms steps by hold_len
  localparam int HOLD_MS [8] = '{0, 250, 500, 750, 1000, 2000, 4000, 6000};

  typedef enum logic [1:0] {
    LM_OFF = 2'h0, LM_ON = 2'h1, LM_IND = 2'h2, LM_GRP = 2'h3
  } lpgd_ledmode_e;

  typedef enum logic [4:0] {
    G_IDLE = 5'h01, G_UP = 5'h02, G_HON = 5'h04, G_DOWN = 5'h08, G_HOFF = 5'h10
  } lpgd_gstate_e;

  typedef struct packed {
    logic rst_n;
    logic oe_n;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic tsd;
  } lpgd_pin_s;
endpackage

// [lpgd_host_model.sv]
// serial bus master model standing in for the host controller
`timescale 1ns/1ps
module lpgd_host_model
  import lpgd_pkg::*;
#(
  parameter int P_SCLK_HALF_NS = 32
) (
  input wire logic i_core_clk, // core clock, aligns frame start and times the gap after each frame
  input wire logic i_sdo, // serial data from the device
  output logic o_cs_n, // chip select, low active
  output logic o_sclk, // serial clock, idle low
  output logic o_sdi // serial data to the device
);
  // idle bus: deselected, clock parked low
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end

  // one frame of two chained words, msb first, 16 bits per device
  // sdi moves while sclk is low; sdo is taken at each rising sclk edge
  // the quarter-ns offset keeps sclk edges off the core clock edges
  // sclk period is set by P_SCLK_HALF_NS; a real host keeps it at or below 10 MHz
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    @(negedge i_core_clk);
    o_cs_n = 1'b0;
    #(0.25);
    for (int b = 31; b >= 0; b--) begin
      o_sdi = w[b];
      #(P_SCLK_HALF_NS);
      o_sclk = 1'b1;
      r[b] = i_sdo;
      #(P_SCLK_HALF_NS);
      o_sclk = 1'b0;
    end
    #(P_SCLK_HALF_NS);
    o_cs_n = 1'b1;
    // a released line shows the inverse so a stale bit never passes for data
    o_sdi = ~w[0];
    repeat (12) @(negedge i_core_clk);
  endtask
endmodule // lpgd_host_model

// [testbench.sv]
// self-checking testbench for the led pwm gradation driver core
`timescale 1ns/1ps
module testbench
  import lpgd_pkg::*;
;
  localparam int PWM_CYC = PWM_OSC * OSC_DIV; // core cycles per pwm period
  localparam int DLY = 1;
  localparam int HMS_OSC = 4; // oscillator ticks per half-ms step in sim
  localparam int HMS_CYC = HMS_OSC * OSC_DIV; // core cycles per half-ms step
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_reset_n = 1'b1;
  logic i_oe_n = 1'b0;
  logic i_tsd = 1'b0;
  logic [NCH-1:0] i_open_det = '0;
  logic [NCH-1:0] i_short_det = '0;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic o_sdo;
  logic [NCH-1:0] o_channel_sink_out;
  logic [NCH-1:0][7:0] o_current_code;
  logic [31:0] rx;
  int miscompares = 0;
  int total_checks = 0;

  // core clock, 5 ns period
  always #2.5 i_core_clk = ~i_core_clk;

  // short half-ms count keeps gradation timing small in simulation
  lpgd_core #(.P_OSC_DIV(OSC_DIV), .P_HALF_MS_OSC(HMS_OSC), .P_DLY(DLY)) DUT (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(1'b1),
    .i_reset_n(i_reset_n),
    .i_oe_n(i_oe_n),
    .i_cs_n(cs_n),
    .i_sclk(sclk),
    .i_sdi(sdi),
    .i_tsd(i_tsd),
    .i_open_det(i_open_det),
    .i_short_det(i_short_det),
    .o_sdo(o_sdo),
    .o_channel_sink_out(o_channel_sink_out),
    .o_current_code(o_current_code)
  );

  lpgd_host_model host (
    .i_core_clk(i_core_clk),
    .i_sdo(o_sdo),
    .o_cs_n(cs_n),
    .o_sclk(sclk),
    .o_sdi(sdi)
  );

  // comparisons, one per kind of result
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t output got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t count got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // chained frame: the leading word must come back out 16 clocks late
  task automatic frame(input logic [15:0] w);
    logic [15:0] lead;
    lead = ~w;
    host.xfer({lead, w}, rx);
    chk_word(rx[15:0], lead);
    chk_out({23'h0, o_sdo}, 24'h0);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frame({a, 1'b0, d});
  endtask

  // read word comes back at the head of the following frame
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    frame({a, 1'b1, 8'h00});
    frame({7'h7f, 1'b1, 8'h00});
    chk_word(rx[31:16], {a, 1'b1, exp});
  endtask

  // cycles in one whole pwm period where channels 1..0 show pat
  // any window of one whole period gives the same count, so no alignment is needed
  task automatic duty(input logic [1:0] pat, input int exp);
    int n;
    n = 0;
    repeat (PWM_CYC) begin
      @(negedge i_core_clk);
      if (o_channel_sink_out[1:0] === pat) n++;
    end
    chk_count(n, exp);
  endtask

  // cycles in a window where channel 0 current code shows lvl
  task automatic grad(input logic [7:0] lvl, input int win, input int exp);
    int n;
    n = 0;
    repeat (win) begin
      @(negedge i_core_clk);
      if (o_current_code[0] === lvl) n++;
    end
    chk_count(n, exp);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog: the sequence needs about 72k cycles
  initial begin
    wait_cyc(90_000);
    miscompares++;
    $display("[FAIL] t=%0t watchdog got %h exp %h", $time, 1'b0, 1'b1);
    finish_test();
  end

  // main sequence
  initial begin
    wait_cyc(4);
    i_sys_rst = 1'b0;
    wait_cyc(6);
    chk_out(o_channel_sink_out, 24'h0);
    rd(A_GRPPWM, 8'hff);
    rd(A_PWM0, 8'h00);
    rd(A_MODE2, 8'h01);
    rd(A_LEDOUT0, 8'haa);
    rd(7'h7f, 8'h00);
    wr(A_IREF0 + 7'd3, 8'hc3);
    rd(A_IREF0 + 7'd3, 8'hc3);
    chk_out({16'h0, o_current_code[3]}, 24'h0000c3);
    // individual pwm: quarter duty, full on
    wr(A_PWM0, 8'h40);
    duty(2'b01, 64 * OSC_DIV);
    wr(A_PWM0, 8'hff);
    duty(2'b01, PWM_CYC);
    // output modes: off ignores pwm, group duty zero gates, on ignores pwm
    wr(A_LEDOUT0, {6'b101010, LM_OFF});
    duty(2'b01, 0);
    wr(A_GRPPWM, 8'h00);
    wr(A_LEDOUT0, {6'b101010, LM_GRP});
    duty(2'b01, 0);
    wr(A_PWM0, 8'h00);
    duty(2'b00, PWM_CYC);
    wr(A_LEDOUT0, {6'b101010, LM_ON});
    duty(2'b01, PWM_CYC);
    // output enable and thermal shutdown blank a constantly-on channel
    i_oe_n = 1'b1;
    wait_cyc(10);
    chk_out(o_channel_sink_out, 24'h0);
    i_oe_n = 1'b0;
    wait_cyc(10);
    chk_out(o_channel_sink_out, 24'h1);
    i_tsd = 1'b1;
    wait_cyc(10);
    chk_out(o_channel_sink_out, 24'h0);
    rd(A_MODE2, 8'h81);
    i_tsd = 1'b0;
    wait_cyc(10);
    chk_out(o_channel_sink_out, 24'h1);
    // stagger: channel 1 lags channel 0 by one delay unit
    wr(A_LEDOUT0, 8'haa);
    wr(A_PWM0, 8'h40);
    wr(A_PWM0 + 7'd1, 8'h40);
    wr(A_MODE1, 8'h02);
    duty(2'b01, DLY * OSC_DIV);
    // sticky error flags, write-1 clear, read-only flag register
    i_short_det[0] = 1'b1;
    i_open_det[5] = 1'b1;
    wait_cyc(10);
    i_short_det = '0;
    i_open_det = '0;
    wait_cyc(10);
    rd(A_EFLAG0, 8'h01);
    rd(A_EFLAG0 + 7'd1, 8'h08);
    wr(A_MODE2, 8'h11);
    wr(A_EFLAG0, 8'hff);
    rd(A_EFLAG0, 8'h00);
    rd(A_EFLAG0 + 7'd1, 8'h00);
    // reset pin brings registers back to their defaults
    wr(A_PWM0 + 7'd5, 8'h5a);
    i_reset_n = 1'b0;
    wait_cyc(5);
    i_reset_n = 1'b1;
    wait_cyc(8);
    chk_out(o_channel_sink_out, 24'h0);
    rd(A_PWM0 + 7'd5, 8'h00);
    rd(A_GRPPWM, 8'hff);
    // gradation: channel 0 on group 0 ramps 0 to 40h and back in 10h steps, one step per half-ms
    rd(A_GSEL0 + 7'd6, 8'h33);
    wr(A_GRP0, 8'hd0);
    wr(A_GRP0 + 7'd3, 8'h40);
    wr(A_GMODE0, 8'h01);
    wr(A_GSTART, 8'h01);
    grad(8'h40, 1000, HMS_CYC);
    chk_out({16'h0, o_current_code[0]}, 24'h0);
    rd(A_GSTART, 8'h00);
    // exponential curve: peak of 40h maps to 40h squared over 256
    wr(A_MODE1, 8'h01);
    wr(A_GSTART, 8'h01);
    grad(8'h10, 1000, HMS_CYC);
    // continuous mode repeats the pattern every eight steps and keeps its start bit
    wr(A_GCONT, 8'h01);
    wr(A_GSTART, 8'h01);
    grad(8'h10, 1600, 2 * HMS_CYC);
    rd(A_GSTART, 8'h01);
    finish_test();
  end
endmodule // testbench
